// File: rtl/gst_timer.sv
// Purpose: gated sixteen bit up-counter with APB register access
// Assumes: presetn is the power-on and brown-out reset
// Notes: zero-wait APB slave; async clocks are sampled on pclk
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module gst_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gst_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_freq_internal_osc,
   input wire logic external_count_pin,
   input wire logic gate_input_pin,
   input wire logic comparator_one_out,
   input wire logic eight_bit_timer_overflow,
   output logic overflow_flag,
   output logic gate_event_flag
);
   import gst_pkg::*;

   gst_main_ctl_type main_ctl_ff;
   gst_gate_ctl_type gate_ctl_ff;
   logic [15:0] count_ff;
   logic ovf_flag_ff;
   logic gate_flag_ff;
   logic [1:0] instr_div_ff;
   logic ext_prev_ff;
   logic osc_prev_ff;
   logic toggle_ff;
   logic pulse_seen_ff;
   logic gate_lvl_ff;
   logic gate_src_prev_ff;
   logic gate_t_prev_ff;
   logic [31:0] prdata_ff;
   logic ext_lvl;
   logic ext_fast;
   logic osc_lvl;
   logic osc_fast;
   logic pin_gate;
   logic cmp_gate;
   logic src_tick;
   logic pre_tick;
   logic gate_raw;
   logic gate_act;
   logic gate_t;
   logic gate_value;
   logic count_en;
   logic wr_acc;
   logic setup;
   logic mapped;
   logic wr_main;
   logic wr_gate;
   logic wr_lo;
   logic wr_hi;
   logic wr_flags;
   logic pulse_done;

   // asynchronous inputs each get their own synchroniser
   gst_sync u_sync_ext
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(external_count_pin),
      .stable_lvl(ext_lvl),
      .fast_rise(ext_fast)
   );
   gst_sync u_sync_osc
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(low_freq_internal_osc),
      .stable_lvl(osc_lvl),
      .fast_rise(osc_fast)
   );
   gst_sync u_sync_gate
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(gate_input_pin),
      .stable_lvl(pin_gate),
      .fast_rise()
   );
   gst_sync u_sync_cmp
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(comparator_one_out),
      .stable_lvl(cmp_gate),
      .fast_rise()
   );

   // apb decode; writes land at the access-phase edge
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign mapped = (paddr == OFS_MAIN_CTL) | (paddr == OFS_GATE_CTL) |
                   (paddr == OFS_COUNT_LO) | (paddr == OFS_COUNT_HI) |
                   (paddr == OFS_FLAGS);
   assign wr_main = wr_acc & (paddr == OFS_MAIN_CTL);
   assign wr_gate = wr_acc & (paddr == OFS_GATE_CTL);
   assign wr_lo = wr_acc & (paddr == OFS_COUNT_LO);
   assign wr_hi = wr_acc & (paddr == OFS_COUNT_HI);
   assign wr_flags = wr_acc & (paddr == OFS_FLAGS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_ff;

   // read data is loaded in the setup cycle so access sees a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_ff <= '0;
      else if (setup & ~pwrite)
      begin
         unique case (paddr)
            OFS_MAIN_CTL: prdata_ff <= {24'h000000,
               main_ctl_ff.clock_source_select,
               main_ctl_ff.prescale_select, 1'b0, main_ctl_ff.sync_disable,
               1'b0, main_ctl_ff.counter_on};
            OFS_GATE_CTL: prdata_ff <= {24'h000000, gate_ctl_ff.gate_enable,
               gate_ctl_ff.gate_polarity, gate_ctl_ff.gate_toggle_mode,
               gate_ctl_ff.gate_single_pulse_mode,
               gate_ctl_ff.pulse_acquire_go, gate_lvl_ff,
               gate_ctl_ff.gate_source_select};
            OFS_COUNT_LO: prdata_ff <= {24'h000000, count_ff[7:0]};
            OFS_COUNT_HI: prdata_ff <= {24'h000000, count_ff[15:8]};
            OFS_FLAGS: prdata_ff <= {30'h00000000, gate_flag_ff, ovf_flag_ff};
            default: prdata_ff <= '0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         main_ctl_ff <= MAIN_CTL_RST;
      else if (wr_main)
      begin
         main_ctl_ff <= pwdata[7:0];
         main_ctl_ff.unused3 <= 1'b0;
         main_ctl_ff.unused1 <= 1'b0;
      end
   end

   // gate control fields in one process; status bit is read from
   // gate_lvl_ff, so the struct copy of it stays at zero
   // go bit
   // software write wins, so a new arm is never lost to completion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_ctl_ff.gate_enable <= 1'b0;
         gate_ctl_ff.gate_polarity <= 1'b0;
         gate_ctl_ff.gate_toggle_mode <= 1'b0;
         gate_ctl_ff.gate_single_pulse_mode <= 1'b0;
         gate_ctl_ff.pulse_acquire_go <= 1'b0;
         gate_ctl_ff.gate_level_status <= 1'b0;
         gate_ctl_ff.gate_source_select <= GS_PIN;
      end
      else if (wr_gate)
      begin
         gate_ctl_ff.gate_enable <= pwdata[7];
         gate_ctl_ff.gate_polarity <= pwdata[6];
         gate_ctl_ff.gate_toggle_mode <= pwdata[5];
         gate_ctl_ff.gate_single_pulse_mode <= pwdata[4];
         gate_ctl_ff.pulse_acquire_go <= pwdata[3];
         gate_ctl_ff.gate_source_select <= pwdata[1:0];
      end
      else if (pulse_done)
         gate_ctl_ff.pulse_acquire_go <= 1'b0;
   end

   // instruction clock tick is every fourth system cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         instr_div_ff <= '0;
      else
         instr_div_ff <= instr_div_ff + 2'h1;
   end

   // edge detectors on the agreed levels
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_prev_ff <= 1'b0;
         osc_prev_ff <= 1'b0;
      end
      else
      begin
         ext_prev_ff <= ext_lvl;
         osc_prev_ff <= osc_lvl;
      end
   end

   always_comb
   begin
      src_tick = 1'b0;
      unique case (main_ctl_ff.clock_source_select)
         CS_INSTR: src_tick = (instr_div_ff == INSTR_DIV_LAST);
         CS_SYSTEM: src_tick = 1'b1;
         CS_EXT_PIN: src_tick = main_ctl_ff.sync_disable ? ext_fast :
                                (ext_lvl & ~ext_prev_ff);
         CS_LFOSC: src_tick = main_ctl_ff.sync_disable ? osc_fast :
                              (osc_lvl & ~osc_prev_ff);
      endcase
   end

   gst_prescale #(.DIV_W(3)) u_prescale
   (
      .pclk(pclk),
      .presetn(presetn),
      .clear(~main_ctl_ff.counter_on),
      .tick_in(src_tick),
      .sel(main_ctl_ff.prescale_select),
      .tick_out(pre_tick)
   );

   always_comb
   begin
      gate_raw = 1'b0;
      unique case (gate_ctl_ff.gate_source_select)
         GS_PIN: gate_raw = pin_gate;
         GS_TMR8: gate_raw = eight_bit_timer_overflow;
         GS_CMP1: gate_raw = cmp_gate;
         GS_RSVD: gate_raw = 1'b0;
      endcase
   end

   assign gate_act = (gate_ctl_ff.gate_source_select == GS_RSVD) ? 1'b0 :
                     (gate_ctl_ff.gate_polarity ? gate_raw : ~gate_raw);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gate_src_prev_ff <= 1'b0;
      else
         gate_src_prev_ff <= gate_act;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         toggle_ff <= 1'b0;
      else if (!main_ctl_ff.counter_on || !gate_ctl_ff.gate_toggle_mode)
         toggle_ff <= 1'b0;
      else if (gate_act & ~gate_src_prev_ff)
         toggle_ff <= ~toggle_ff;
   end

   assign gate_t = gate_ctl_ff.gate_toggle_mode ? toggle_ff : gate_act;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gate_t_prev_ff <= 1'b0;
      else
         gate_t_prev_ff <= gate_t;
   end

   assign gate_value = gate_ctl_ff.gate_single_pulse_mode ?
                       (gate_t & gate_ctl_ff.pulse_acquire_go) : gate_t;
   assign pulse_done = gate_ctl_ff.gate_single_pulse_mode &
                       gate_ctl_ff.pulse_acquire_go & pulse_seen_ff &
                       gate_t_prev_ff & ~gate_t;

   // remembers that the armed pulse has started
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pulse_seen_ff <= 1'b0;
      else if (!gate_ctl_ff.pulse_acquire_go || pulse_done)
         pulse_seen_ff <= 1'b0;
      else if (gate_t)
         pulse_seen_ff <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gate_lvl_ff <= 1'b0;
      else
         gate_lvl_ff <= gate_value;
   end

   assign count_en = main_ctl_ff.counter_on & pre_tick &
                     (~gate_ctl_ff.gate_enable | gate_value);

   // counter; a byte write beats an increment in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_ff <= COUNT_RST;
      else if (wr_lo)
         count_ff[7:0] <= pwdata[7:0];
      else if (wr_hi)
         count_ff[15:8] <= pwdata[7:0];
      else if (count_en)
         count_ff <= count_ff + 16'h0001;
   end

   // write one to clear; a same-cycle event keeps the flag set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ovf_flag_ff <= 1'b0;
         gate_flag_ff <= 1'b0;
      end
      else
      begin
         if (count_en && !wr_lo && !wr_hi && count_ff == COUNT_MAX)
            ovf_flag_ff <= 1'b1;
         else if (wr_flags && pwdata[FLAG_OVF_BIT])
            ovf_flag_ff <= 1'b0;
         if (gate_lvl_ff && !gate_value)
            gate_flag_ff <= 1'b1;
         else if (wr_flags && pwdata[FLAG_GATE_BIT])
            gate_flag_ff <= 1'b0;
      end
   end

   assign overflow_flag = ovf_flag_ff;
   assign gate_event_flag = gate_flag_ff;
endmodule : gst_timer

// File: rtl/gst_pkg.sv
// Purpose: shared constants and types for the gated sixteen bit timer
// Assumes: 32-bit APB data, registers in the low byte of each word
// Notes: control layouts are packed structs in register bit order
package gst_pkg;
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] OFS_MAIN_CTL = 12'h000;
   localparam logic [APB_AW-1:0] OFS_GATE_CTL = 12'h004;
   localparam logic [APB_AW-1:0] OFS_COUNT_LO = 12'h008;
   localparam logic [APB_AW-1:0] OFS_COUNT_HI = 12'h00c;
   localparam logic [APB_AW-1:0] OFS_FLAGS = 12'h010;
   // flag register bit positions
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_GATE_BIT = 1;
   // clock source codes
   localparam logic [1:0] CS_INSTR = 2'h0;
   localparam logic [1:0] CS_SYSTEM = 2'h1;
   localparam logic [1:0] CS_EXT_PIN = 2'h2;
   localparam logic [1:0] CS_LFOSC = 2'h3;
   // gate source codes
   localparam logic [1:0] GS_PIN = 2'h0;
   localparam logic [1:0] GS_TMR8 = 2'h1;
   localparam logic [1:0] GS_CMP1 = 2'h2;
   localparam logic [1:0] GS_RSVD = 2'h3;
   // instruction clock is the system clock divided by four
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_RST = 16'h0000;

   typedef struct packed {
      logic [1:0] clock_source_select;
      logic [1:0] prescale_select;
      logic unused3;
      logic sync_disable;
      logic unused1;
      logic counter_on;
   } gst_main_ctl_type;

   typedef struct packed {
      logic gate_enable;
      logic gate_polarity;
      logic gate_toggle_mode;
      logic gate_single_pulse_mode;
      logic pulse_acquire_go;
      logic gate_level_status;
      logic [1:0] gate_source_select;
   } gst_gate_ctl_type;

   localparam gst_main_ctl_type MAIN_CTL_RST = '0;
   localparam gst_gate_ctl_type GATE_CTL_RST = '0;
endpackage : gst_pkg

// File: rtl/gst_sync.sv
// Purpose: three-stage synchroniser for one asynchronous input
// Assumes: input is unrelated to pclk
// Notes: stable level changes only once stages two and three agree
`timescale 1ns/1ps
module gst_sync
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic async_in,
   output logic stable_lvl,
   output logic fast_rise
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic stable_ff;

   // capture chain; stage one feeds only stage two
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // agreement filter rejects a single metastable sample
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stable_ff <= 1'b0;
      else if (s2_ff == s3_ff)
         stable_ff <= s3_ff;
   end

   assign stable_lvl = stable_ff;
   // quicker edge without agreement, used when sync is turned off
   assign fast_rise = s2_ff & ~s3_ff;
endmodule : gst_sync

// File: rtl/gst_prescale.sv
// Purpose: divide a tick stream by 1, 2, 4 or 8
// Assumes: tick_in is a one-cycle pulse on pclk
// Notes: clear restarts the division phase
`timescale 1ns/1ps
module gst_prescale
#(
   parameter int DIV_W = 3
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [1:0] sel,
   output logic tick_out
);
   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] mask;

   // low sel bits of the counter must all be ones to pass a tick
   assign mask = DIV_W'((1 << sel) - 1);
   assign tick_out = tick_in & ((cnt_ff & mask) == mask);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_ff <= '0;
      else if (clear)
         cnt_ff <= '0;
      else if (tick_in)
         cnt_ff <= cnt_ff + DIV_W'(1);
   end
endmodule : gst_prescale

// File: tb/gst_timer_monitor.sv
// Purpose: bus and flag checks on the gated timer ports
// Assumes: zero-wait slave, flags cleared by write-one at OFS_FLAGS
// Notes: set-wins races on the flags are left to the bench
`timescale 1ns/1ps
module gst_timer_monitor
import gst_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic overflow_flag,
   input wire logic gate_event_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // helper decode, kept combinational so it follows paddr at once
   logic mapped;
   logic clr_ovf;
   logic clr_gev;
   assign mapped = paddr inside {OFS_MAIN_CTL, OFS_GATE_CTL,
      OFS_COUNT_LO, OFS_COUNT_HI, OFS_FLAGS};
   assign clr_ovf = psel && penable && pwrite && paddr == OFS_FLAGS
      && pwdata[FLAG_OVF_BIT];
   assign clr_gev = psel && penable && pwrite && paddr == OFS_FLAGS
      && pwdata[FLAG_GATE_BIT];
   // one access phase, then its kind
   sequence acc_s;
      psel && penable;
   endsequence
   sequence hole_s;
      acc_s ##0 !mapped;
   endsequence
   ready_high_a: assert property (pready)
      else $error("pready low");
   err_hole_a: assert property (hole_s |-> pslverr)
      else $error("unmapped access without pslverr");
   err_quiet_a: assert property (!(psel && penable) || mapped |-> !pslverr)
      else $error("spurious pslverr");
   hole_zero_a: assert property (hole_s ##0 !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   rst_clear_a: assert property ($rose(presetn) |-> !overflow_flag
      && !gate_event_flag && prdata == 32'h0)
      else $error("state not cleared by reset");
   ovf_hold_a: assert property (overflow_flag && !clr_ovf |=>
      overflow_flag)
      else $error("overflow flag lost");
   gate_hold_a: assert property (gate_event_flag && !clr_gev |=>
      gate_event_flag)
      else $error("gate event flag lost");
endmodule : gst_timer_monitor

bind gst_timer gst_timer_monitor u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .overflow_flag(overflow_flag), .gate_event_flag(gate_event_flag));

// File: tb/gst_src_model.sv
// Purpose: stand-in for the counting clock and gate pin sources
// Assumes: sources are unrelated in phase to pclk
// Notes: the clock idles low between runs, as a stopped oscillator would
`timescale 1ns/1ps
module gst_src_model
#(
   parameter int HALF_NS = 47
)
(
   input wire logic run,
   input wire logic gate_lvl,
   output logic ext_clk,
   output logic gate_pin
);
   // edges only while a count run is requested
   initial ext_clk = 1'b0;
   always #HALF_NS ext_clk = run ? ~ext_clk : 1'b0;
   // gate pin follows the requested level
   assign gate_pin = gate_lvl;
endmodule : gst_src_model

// File: tb/testbench.sv
// Purpose: register and counting scenarios for the gated timer
// Assumes: zero-wait APB slave, register values in bits 7:0
// Notes: count windows carry a small tolerance for sync latency
`timescale 1ns/1ps
module testbench;
   import gst_pkg::*;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, run, gate_lvl;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, ext_clk, gate_pin, ovf, gev, er;
   logic [15:0] cnt;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;

   // 100 MHz system clock
   always #5 pclk = ~pclk;

   gst_src_model src (.run(run), .gate_lvl(gate_lvl), .ext_clk(ext_clk),
      .gate_pin(gate_pin));
   gst_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_freq_internal_osc(ext_clk), .external_count_pin(ext_clk),
      .gate_input_pin(gate_pin), .comparator_one_out(~gate_pin),
      .eight_bit_timer_overflow(gate_lvl), .overflow_flag(ovf),
      .gate_event_flag(gev));

   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         complete_run;
      end
   end

   // range compare; an unknown never counts as inside
   task automatic chk(input string nm, input logic [31:0] lo,
      input logic [31:0] hi, input logic [31:0] got);
      checks++;
      if (((got >= lo) && (got <= hi)) !== 1'b1)
      begin
         miscompares++;
         $display("[FAIL] %s expected %0h..%0h seen %0h", nm, lo, hi, got);
      end
   endtask : chk

   // one APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [APB_AW-1:0] a,
      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_cnt;
      apb(1'b0, OFS_COUNT_LO, 8'h00);
      cnt[7:0] = rd[7:0];
      apb(1'b0, OFS_COUNT_HI, 8'h00);
      cnt[15:8] = rd[7:0];
   endtask : rd_cnt

   // zero the count, run n cycles with control byte mc, stop, read back
   task automatic run_cnt(input logic [7:0] mc, input int n);
      apb(1'b1, OFS_COUNT_LO, 8'h00);
      apb(1'b1, OFS_COUNT_HI, 8'h00);
      apb(1'b1, OFS_MAIN_CTL, mc);
      repeat (n) @(posedge pclk);
      apb(1'b1, OFS_MAIN_CTL, mc & 8'hfe);
      rd_cnt;
   endtask : run_cnt

   task automatic pin(input logic v, input int n);
      @(posedge pclk);
      gate_lvl <= v;
      repeat (n) @(posedge pclk);
   endtask : pin

   task automatic t_reset;
      apb(1'b0, OFS_MAIN_CTL, 8'h00);
      chk("main", 0, 0, rd);
      apb(1'b0, OFS_GATE_CTL, 8'h00);
      chk("gate", 0, 0, rd & 32'hfb);
      apb(1'b0, OFS_FLAGS, 8'h00);
      chk("flags", 0, 0, rd);
   endtask : t_reset

   task automatic t_map;
      apb(1'b1, OFS_MAIN_CTL, 8'h3e);
      apb(1'b0, OFS_MAIN_CTL, 8'h00);
      chk("main holes", 32'h34, 32'h34, rd);
      apb(1'b1, 12'h014, 8'hff);
      apb(1'b0, 12'h014, 8'h00);
      chk("hole err", 1, 1, {31'h0, er});
      apb(1'b1, OFS_MAIN_CTL, 8'h00);
   endtask : t_map

   task automatic t_clk;
      logic [1:0] cs;
      for (int p = 0; p < 4; p++)
      begin
         run_cnt({CS_SYSTEM, 2'(p), 4'h1}, 61);
         chk("prescale", (64 >> p) - 2, (64 >> p) + 2, cnt);
      end
      run_cnt({CS_INSTR, 4'h1}, 61);
      chk("instr clk", 14, 18, cnt);
      run = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         cs = i[1] ? CS_LFOSC : CS_EXT_PIN;
         run_cnt({cs, 3'h0, i[0], 2'h1}, 197);
         chk("async clk", 18, 24, cnt);
      end
      run = 1'b0;
   endtask : t_clk

   task automatic t_ovf;
      apb(1'b1, OFS_COUNT_LO, 8'hff);
      apb(1'b1, OFS_COUNT_HI, 8'hff);
      apb(1'b1, OFS_MAIN_CTL, 8'h41);
      repeat (4) @(posedge pclk);
      apb(1'b1, OFS_MAIN_CTL, 8'h40);
      rd_cnt;
      chk("rollover", 1, 12, cnt);
      chk("ovf set", 1, 1, {31'h0, ovf});
      apb(1'b1, OFS_FLAGS, 8'h01);
      @(negedge pclk);
      chk("ovf clear", 0, 0, {31'h0, ovf});
   endtask : t_ovf

   task automatic t_gate;
      // gate configs: active high, low, reserved, off, timer8, comparator
      // comparator sees the inverted pin, timer8 the pin level itself
      logic [7:0] gc [6] = '{8'hc0, 8'h80, 8'hc3, 8'h00, 8'hc1, 8'hc2};
      int hi [6] = '{66, 0, 0, 66, 66, 0};
      pin(1'b0, 10);
      apb(1'b1, OFS_GATE_CTL, 8'hc0);
      run_cnt(8'h41, 61);
      chk("gate low", 0, 0, cnt);
      pin(1'b1, 10);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, OFS_GATE_CTL, gc[i]);
         run_cnt(8'h41, 61);
         chk("gating", hi[i] ? 62 : 0, hi[i], cnt);
      end
      apb(1'b1, OFS_GATE_CTL, 8'h40);
      apb(1'b1, OFS_FLAGS, 8'h02);
      apb(1'b0, OFS_GATE_CTL, 8'h00);
      chk("level hi", 4, 4, rd & 32'h4);
      pin(1'b0, 10);
      chk("gate evt", 1, 1, {31'h0, gev});
      apb(1'b0, OFS_GATE_CTL, 8'h00);
      chk("level lo", 0, 0, rd & 32'h4);
      apb(1'b1, OFS_FLAGS, 8'h02);
   endtask : t_gate

   task automatic t_pulse;
      logic [15:0] first;
      apb(1'b1, OFS_GATE_CTL, 8'hd0);
      run_cnt(8'h41, 8);
      apb(1'b1, OFS_MAIN_CTL, 8'h41);
      apb(1'b1, OFS_GATE_CTL, 8'hd8);
      apb(1'b0, OFS_GATE_CTL, 8'h00);
      chk("armed", 8, 8, rd & 32'h8);
      pin(1'b1, 20);
      pin(1'b0, 10);
      apb(1'b0, OFS_GATE_CTL, 8'h00);
      chk("done", 0, 0, rd & 32'h8);
      rd_cnt;
      first = cnt;
      chk("pulse len", 17, 24, cnt);
      pin(1'b1, 20);
      pin(1'b0, 10);
      rd_cnt;
      chk("no rearm", first, first, cnt);
      apb(1'b1, OFS_MAIN_CTL, 8'h40);
   endtask : t_pulse

   task automatic t_toggle;
      logic [15:0] held;
      apb(1'b1, OFS_GATE_CTL, 8'he0);
      run_cnt(8'h41, 8);
      apb(1'b1, OFS_MAIN_CTL, 8'h41);
      pin(1'b1, 10);
      pin(1'b0, 10);
      pin(1'b1, 10);
      pin(1'b0, 10);
      rd_cnt;
      chk("full period", 18, 23, cnt);
      // a rise sets the toggle flop; turning off must clear it
      pin(1'b1, 10);
      apb(1'b1, OFS_MAIN_CTL, 8'h40);
      apb(1'b1, OFS_MAIN_CTL, 8'h41);
      rd_cnt;
      held = cnt;
      pin(1'b1, 10);
      rd_cnt;
      chk("off clears", held, held, cnt);
      apb(1'b1, OFS_MAIN_CTL, 8'h40);
   endtask : t_toggle

   // reset for five cycles, then the scenarios in turn
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      run = 1'b0;
      gate_lvl = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_map;
      t_clk;
      t_ovf;
      t_gate;
      t_pulse;
      t_toggle;
      complete_run;
   end
endmodule : testbench
